// ===== seq_consts.svh
/*
 Constants of the optical sample sequencer and its host controller:
 register offsets, field positions, reset values and timing counts.
 Assumes inclusion by bare name from the package and the two ends.
*/
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// device register offsets
`define REG_MODE 8'h10
`define REG_FSEL 8'h12
`define REG_AVG 8'h15
`define REG_PCNT_A 8'h31
`define REG_PCNT_B 8'h36
`define REG_SYNC 8'h38
`define REG_CLK 8'h4B
`define REG_IO 8'h4F
`define REG_OUT_A_LO 8'h64
`define REG_OUT_A_HI 8'h65
`define REG_OUT_B_LO 8'h66
`define REG_OUT_B_HI 8'h67

// reset values
`define MODE_RST 16'h0000
`define FSEL_RST 16'h0140
`define AVG_RST 16'h0000
`define PCNT_RST 16'h0100
`define SYNC_RST 16'h0000
`define CLK_RST 16'h0000
`define IO_RST 16'h0000

// fields
`define MODE_HI 1
`define MODE_LO 0
`define MODE_STANDBY 2'h0
`define MODE_PROGRAM 2'h1
`define MODE_NORMAL 2'h2
`define CLKSEL_HI 8
`define CLKSEL_LO 7
`define CLKSEL_EXT 2'h2
`define IO_SYNC_HI 3
`define IO_SYNC_LO 2
`define SYNC_PIN0 2'h1
`define SYNC_PIN1 2'h2
`define IO_BUF0 1
`define IO_BUF1 5
`define IO_PIN1_HI 6
`define IO_PIN1_LO 5
`define PIN1_INPUT 2'h1
`define AVG_A_LO 4
`define AVG_B_LO 8
`define PCNT_HI 15
`define PCNT_LO 8
`define PSUM_MAX 20'hFFFFF

// timing
`define SYS_CLK_HZ 10000000
`define SAMPLE_CLK_HZ 32000
`define TICK_CYCLES (`SYS_CLK_HZ / `SAMPLE_CLK_HZ)

// host apb map
`define APB_CMD 12'h000
`define APB_STAT 12'h004
`define APB_PINS 12'h008
`define CMD_ADDR_HI 7
`define CMD_WDATA_HI 23
`define CMD_WDATA_LO 8
`define CMD_WRITE 24

`endif

// ===== seq_pkg.sv
/*
 Types of the optical sample sequencer and its host controller.
 Assumes seq_consts.svh is reachable by bare name.
*/
`include "seq_consts.svh"

package seq_pkg;

    typedef enum logic [2:0] {SEQ_IDLE, SEQ_WAKE, SEQ_SLOT, SEQ_PULSE, SEQ_STORE} seq_state_t;

    typedef enum logic {HOST_IDLE, HOST_WAIT} host_state_t;

    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] fsel;
        logic [15:0] avg;
        logic [15:0] pcnt_a;
        logic [15:0] pcnt_b;
        logic [15:0] syncc;
        logic [15:0] clkc;
        logic [15:0] io;
        logic [15:0] rdata;
        logic ack;
        logic g0_s1;
        logic g0_s2;
        logic g1_s1;
        logic g1_s2;
        logic g0_prev;
        logic g1_prev;
        logic [8:0] tick_cnt;
        logic [15:0] tmr;
        logic trig_pend;
        seq_state_t state;
        logic slot_b;
        logic [7:0] pcnt;
        logic [19:0] psum;
        logic [1:0][26:0] acc;
        logic [1:0][7:0] navg;
        logic [1:0][31:0] outd;
        logic [31:0] fifo_data;
        logic fifo_valid;
        logic fifo_slot;
    } dev_state_t;

    typedef struct packed {
        host_state_t state;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata_last;
        logic [3:0] pins;
    } host_reg_t;

endpackage : seq_pkg

// ===== sensor_link_if.sv
/*
 Link between host controller and sequencer: register port and two pins.
 Assumes one clock shared by both ends; undriven pins read low.
*/
`timescale 1ns/1ps

interface sensor_link_if;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic reg_ack;
    logic pin_zero_drv;
    logic pin_zero_oe;
    logic pin_one_drv;
    logic pin_one_oe;
    logic general_io_pin_zero;
    logic general_io_pin_one;

    // pin level with weak pull-down when nobody drives
    assign general_io_pin_zero = pin_zero_oe & pin_zero_drv;
    assign general_io_pin_one = pin_one_oe & pin_one_drv;

    modport dev (
        input reg_addr, reg_wdata, reg_wr, reg_rd, general_io_pin_zero, general_io_pin_one,
        output reg_rdata, reg_ack
    );

    modport host (
        output reg_addr, reg_wdata, reg_wr, reg_rd, pin_zero_drv, pin_zero_oe, pin_one_drv,
            pin_one_oe,
        input reg_rdata, reg_ack
    );
endinterface : sensor_link_if

// ===== sample_sequencer_dev.sv
/*
 Sequencer end: mode register, sample triggering, pulse accumulation and
 intersample averaging with output registers and a divided FIFO stream.
 Assumes the host keeps the register port handshake and an ADC that
 answers each pulse request with one valid strobe.
*/
// Rules for this block and for the host that drives it
// R1: sync pin chosen by two-bit io field
// R2: sync edge starts sample after 1-2 ticks
// R3: sync start reuses internal start sequence
// R4: host programs sync setup then normal mode
// R5: io bits 1 and 5 enable buffers
// R6: host keeps sync rate within maximum
// R7: clock field 10 selects pin one clock
// R8: host drives pin one before enabling it
// R9: mode field: standby, program, normal
// R10: reset into standby; standby collects nothing
// R11: host passes program mode for changes
// R12: sample sums 1 to 255 pulses
// R13: 14-bit conversions summed, clipped at 20 bits
// R14: averaging factor power of two, output every Nth
// R15: output registers hold full undivided sum
// R16: FIFO gets sum divided by N
// R17: pulse count 4 or less fits 16 bits
// R18: both slots feed FIFO only if factors equal
// R19: results via output registers and FIFO
// R20: slot A then slot B each period
// R21: sample rate from 32 kHz tick
// R22: internal timer repeats in normal mode
// R23: leaving normal stops new periods
`timescale 1ns/1ps
`include "seq_consts.svh"

module sample_sequencer_dev
    import seq_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    sensor_link_if.dev lnk,
    input wire logic adc_valid_in,
    input wire logic [13:0] adc_data_in,
    output logic pulse_req_out,
    output logic fifo_valid_out,
    output logic [31:0] fifo_data_out,
    output logic fifo_slot_out,
    output logic [1:0] mode_out
);

    dev_state_t r;
    dev_state_t n;

    localparam logic [8:0] TICK_LAST = 9'(`TICK_CYCLES - 1);

    function automatic logic [19:0] sat_add(input logic [19:0] a, input logic [13:0] b);
        logic [20:0] s;
        s = {1'b0, a} + {7'h00, b};
        return s[20] ? `PSUM_MAX : s[19:0];
    endfunction : sat_add

    function automatic logic [7:0] avg_n(input logic [2:0] lg);
        return 8'(9'h001 << lg);
    endfunction : avg_n

    logic g0_in;
    logic g1_in;
    logic g0_rise;
    logic g1_rise;
    logic ext_clk;
    logic tick;
    logic [1:0] sync_sel;
    logic sync_on;
    logic sync_rise;
    logic normal;
    logic trigger;
    logic [2:0] lg_a;
    logic [2:0] lg_b;
    logic [2:0] lg_cur;
    logic [7:0] npl;
    logic [26:0] sum;

    always_comb begin
        n = r;
        n.ack = 1'b0;
        n.fifo_valid = 1'b0;
        n.g0_s1 = lnk.general_io_pin_zero;
        n.g0_s2 = r.g0_s1;
        n.g1_s1 = lnk.general_io_pin_one;
        n.g1_s2 = r.g1_s1;
        // register port, one ack per request
        if ((lnk.reg_wr || lnk.reg_rd) && !r.ack) begin
            n.ack = 1'b1;
            if (lnk.reg_wr) begin
                case (lnk.reg_addr)
                    `REG_MODE: n.mode = lnk.reg_wdata; // R9
                    `REG_FSEL: n.fsel = lnk.reg_wdata;
                    `REG_AVG: n.avg = lnk.reg_wdata;
                    `REG_PCNT_A: n.pcnt_a = lnk.reg_wdata;
                    `REG_PCNT_B: n.pcnt_b = lnk.reg_wdata;
                    `REG_SYNC: n.syncc = lnk.reg_wdata;
                    `REG_CLK: n.clkc = lnk.reg_wdata;
                    `REG_IO: n.io = lnk.reg_wdata;
                    default: ;
                endcase
            end else begin
                case (lnk.reg_addr)
                    `REG_MODE: n.rdata = r.mode;
                    `REG_FSEL: n.rdata = r.fsel;
                    `REG_AVG: n.rdata = r.avg;
                    `REG_PCNT_A: n.rdata = r.pcnt_a;
                    `REG_PCNT_B: n.rdata = r.pcnt_b;
                    `REG_SYNC: n.rdata = r.syncc;
                    `REG_CLK: n.rdata = r.clkc;
                    `REG_IO: n.rdata = r.io;
                    `REG_OUT_A_LO: n.rdata = r.outd[0][15:0]; // R19
                    `REG_OUT_A_HI: n.rdata = r.outd[0][31:16];
                    `REG_OUT_B_LO: n.rdata = r.outd[1][15:0];
                    `REG_OUT_B_HI: n.rdata = r.outd[1][31:16];
                    default: n.rdata = 16'h0000;
                endcase
            end
        end

        // input buffers gate the synchronised pins
        g0_in = r.g0_s2 & r.io[`IO_BUF0]; // R5
        g1_in = r.g1_s2 & (r.io[`IO_BUF1] | (r.io[`IO_PIN1_HI:`IO_PIN1_LO] == `PIN1_INPUT)); // R5
        n.g0_prev = g0_in;
        n.g1_prev = g1_in;
        g0_rise = g0_in & ~r.g0_prev;
        g1_rise = g1_in & ~r.g1_prev;

        // 32 kHz tick: internal divider or pin one clock
        ext_clk = (r.clkc[`CLKSEL_HI:`CLKSEL_LO] == `CLKSEL_EXT); // R7
        if (ext_clk) begin
            n.tick_cnt = 9'h000; // R7
            tick = g1_rise; // R7
        end else begin
            n.tick_cnt = (r.tick_cnt == TICK_LAST) ? 9'h000 : r.tick_cnt + 9'h001; // R21
            tick = (r.tick_cnt == TICK_LAST); // R21
        end

        sync_sel = r.io[`IO_SYNC_HI:`IO_SYNC_LO]; // R1
        sync_on = (sync_sel == `SYNC_PIN0) || (sync_sel == `SYNC_PIN1); // R1
        sync_rise = (sync_sel == `SYNC_PIN0) ? g0_rise : ((sync_sel == `SYNC_PIN1) ? g1_rise : 1'b0); // R1
        normal = (r.mode[`MODE_HI:`MODE_LO] == `MODE_NORMAL); // R9

        lg_a = r.avg[`AVG_A_LO +: 3];
        lg_b = r.avg[`AVG_B_LO +: 3];
        lg_cur = r.slot_b ? lg_b : lg_a;
        npl = r.slot_b ? r.pcnt_b[`PCNT_HI:`PCNT_LO] : r.pcnt_a[`PCNT_HI:`PCNT_LO];
        sum = r.acc[r.slot_b] + {7'h00, r.psum};
        trigger = 1'b0;

        case (r.state)
            SEQ_IDLE: begin
                if (tick) begin
                    n.tmr = r.tmr + 16'h0001; // R21
                    if (sync_on) begin
                        trigger = r.trig_pend; // R2
                    end else if ({1'b0, r.tmr} + 17'h00001 >= {1'b0, r.fsel}) begin
                        trigger = 1'b1; // R22
                    end
                end
                if (trigger) begin
                    n.tmr = 16'h0000;
                    n.trig_pend = 1'b0;
                    n.state = SEQ_WAKE; // R3
                end
            end
            SEQ_WAKE: begin
                if (tick) begin
                    n.slot_b = 1'b0; // R20
                    n.state = SEQ_SLOT;
                end
            end
            SEQ_SLOT: begin
                n.psum = 20'h00000;
                n.pcnt = 8'h00;
                // zero pulses leaves the slot unused
                if (npl == 8'h00) begin
                    n.slot_b = 1'b1;
                    n.state = r.slot_b ? SEQ_IDLE : SEQ_SLOT;
                end else begin
                    n.state = SEQ_PULSE;
                end
            end
            SEQ_PULSE: begin
                if (adc_valid_in) begin
                    n.psum = sat_add(r.psum, adc_data_in); // R13
                    n.pcnt = r.pcnt + 8'h01;
                    if (r.pcnt + 8'h01 == npl) begin
                        n.state = SEQ_STORE; // R12
                    end
                end
            end
            SEQ_STORE: begin
                if (r.navg[r.slot_b] + 8'h01 == avg_n(lg_cur)) begin
                    n.outd[r.slot_b] = {5'h00, sum}; // R15
                    n.acc[r.slot_b] = 27'h0000000; // R14
                    n.navg[r.slot_b] = 8'h00;
                    if (!r.slot_b || (lg_a == lg_b)) begin
                        n.fifo_valid = 1'b1; // R18
                        n.fifo_slot = r.slot_b;
                        n.fifo_data = {5'h00, sum >> lg_cur}; // R16 R17
                    end
                end else begin
                    n.acc[r.slot_b] = sum; // R14
                    n.navg[r.slot_b] = r.navg[r.slot_b] + 8'h01;
                end
                n.slot_b = 1'b1;
                n.state = r.slot_b ? SEQ_IDLE : SEQ_SLOT; // R20
            end
            default: n.state = SEQ_IDLE;
        endcase

        // a new edge wins over the clear above
        if (sync_on && sync_rise) begin
            n.trig_pend = 1'b1; // R2
        end
        if (!normal) begin
            n.state = SEQ_IDLE; // R10 R23
            n.trig_pend = 1'b0; // R23
            n.tmr = 16'h0000;
            // aborted period stores and pushes nothing; averaging restarts
            n.fifo_valid = 1'b0; // R10
            n.outd = r.outd;
            n.acc = '0;
            n.navg = '0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r <= '0;
            r.mode <= `MODE_RST; // R10
            r.fsel <= `FSEL_RST;
            r.avg <= `AVG_RST;
            r.pcnt_a <= `PCNT_RST;
            r.pcnt_b <= `PCNT_RST;
            r.syncc <= `SYNC_RST;
            r.clkc <= `CLK_RST;
            r.io <= `IO_RST;
            r.state <= SEQ_IDLE;
        end else begin
            r <= n;
        end
    end

    assign lnk.reg_rdata = r.rdata;
    assign lnk.reg_ack = r.ack;
    assign pulse_req_out = (r.state == SEQ_PULSE);
    assign fifo_valid_out = r.fifo_valid;
    assign fifo_data_out = r.fifo_data;
    assign fifo_slot_out = r.fifo_slot;
    assign mode_out = r.mode[`MODE_HI:`MODE_LO];

endmodule : sample_sequencer_dev

// ===== sample_host_ctrl.sv
/*
 Host end: APB slave whose registers relay software register accesses
 onto the sequencer link and drive the two general pins.
 Assumes software orders the accesses and pin levels as the device needs.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module sample_host_ctrl
    import seq_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    sensor_link_if.host lnk,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out
);

    host_reg_t r;
    host_reg_t n;
    logic access;
    logic mapped;

    always_comb begin
        n = r;
        access = psel_in & penable_in;
        mapped = (paddr_in == `APB_CMD) || (paddr_in == `APB_STAT) || (paddr_in == `APB_PINS);
        if (access && pwrite_in) begin
            case (paddr_in)
                `APB_CMD: begin
                    // relayed one at a time, in software order
                    if (r.state == HOST_IDLE) begin
                        n.addr = pwdata_in[`CMD_ADDR_HI:0]; // R4 R11
                        n.wdata = pwdata_in[`CMD_WDATA_HI:`CMD_WDATA_LO];
                        n.wr = pwdata_in[`CMD_WRITE];
                        n.rd = ~pwdata_in[`CMD_WRITE]; // R19
                        n.state = HOST_WAIT;
                    end
                end
                `APB_PINS: n.pins = pwdata_in[3:0]; // R6 R8
                default: ;
            endcase
        end
        case (r.state)
            HOST_IDLE: ;
            HOST_WAIT: begin
                if (lnk.reg_ack) begin
                    if (r.rd) begin
                        n.rdata_last = lnk.reg_rdata;
                    end
                    n.wr = 1'b0;
                    n.rd = 1'b0;
                    n.state = HOST_IDLE;
                end
            end
            default: n.state = HOST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r <= '0;
            r.state <= HOST_IDLE;
        end else begin
            r <= n;
        end
    end

    always_comb begin
        case (paddr_in)
            `APB_CMD: prdata_out = {7'h00, r.wr, r.wdata, r.addr};
            `APB_STAT: prdata_out = {r.rdata_last, 15'h0000, (r.state == HOST_WAIT)};
            `APB_PINS: prdata_out = {28'h0000000, r.pins};
            default: prdata_out = 32'h00000000;
        endcase
    end

    assign pready_out = 1'b1;
    assign pslverr_out = access & ~mapped;
    assign lnk.reg_addr = r.addr;
    assign lnk.reg_wdata = r.wdata;
    assign lnk.reg_wr = r.wr;
    assign lnk.reg_rd = r.rd;
    assign lnk.pin_zero_drv = r.pins[0];
    assign lnk.pin_zero_oe = r.pins[1];
    assign lnk.pin_one_drv = r.pins[2];
    assign lnk.pin_one_oe = r.pins[3];

endmodule : sample_host_ctrl

// ===== seq_link_properties.sv
/*
 Concurrent checks on the sequencer link and the sequencer outputs.
 Assumes one clock domain; instantiated beside the link interface.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module seq_link_properties (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic adc_valid_in,
    input wire logic pulse_req_out,
    input wire logic fifo_valid_out,
    input wire logic [1:0] mode_out
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    a_ack_next_cycle: assert property ((reg_wr || reg_rd) && !reg_ack |=> reg_ack)
        else $error("link ack not one cycle after request");
    a_ack_single_pulse: assert property (reg_ack |=> !reg_ack)
        else $error("link ack longer than one cycle");
    a_ack_has_cause: assert property ($rose(reg_ack) |-> $past(reg_wr) || $past(reg_rd))
        else $error("link ack without request");
    a_rdata_on_read: assert property (!$stable(reg_rdata) |-> reg_ack && $past(reg_rd))
        else $error("read data changed outside read ack");
    a_mode_write_lands: assert property (reg_ack && $past(reg_wr) && $past(reg_addr) == `REG_MODE
        |-> mode_out == 2'($past(reg_wdata)))
        else $error("mode field not taken from write");
    a_req_holds_wait: assert property (pulse_req_out && !adc_valid_in
        && mode_out == `MODE_NORMAL |=> pulse_req_out)
        else $error("pulse request dropped before conversion");
    a_pulse_in_normal: assert property ($rose(pulse_req_out) |-> $past(mode_out) == `MODE_NORMAL)
        else $error("pulse request outside normal mode");
    a_push_in_normal: assert property (fifo_valid_out |-> $past(mode_out) == `MODE_NORMAL)
        else $error("fifo push outside normal mode");
    a_idle_is_quiet: assert property ((mode_out != `MODE_NORMAL) [*3]
        |-> !pulse_req_out && !fifo_valid_out)
        else $error("activity while not in normal mode");

    c_read_done: cover property (reg_ack && $past(reg_rd));
    c_pulse_start: cover property ($rose(pulse_req_out));
    c_fifo_push: cover property (fifo_valid_out);
endmodule : seq_link_properties

// ===== tb_top.sv
/*
 Self-checking bench: host controller and sequencer joined by the link.
 Assumes the design files and the link checker are compiled first.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module tb_top;
    typedef struct packed {logic [7:0] n; logic [13:0] adc; logic [2:0] la; logic [2:0] lb;
        logic [19:0] ex;} row_t;
    localparam int TK = `TICK_CYCLES;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, adc_valid = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [13:0] adc_data = 14'h0000;
    logic [31:0] prdata, fifo_data;
    logic pready, pslverr, pulse_req, fifo_valid, fifo_slot;
    logic [1:0] mode;
    int bad_count = 0;
    int samples_checked = 0;
    int slot_cnt [2] = '{0, 0};
    logic [31:0] last_data [2];
    // per-sample sum: pulses times conversion, clipped to 20 bits
    row_t rows [4] = '{'{8'd1, 14'h3FFF, 3'd1, 3'd1, 20'h03FFF},
        '{8'd255, 14'h3FFF, 3'd2, 3'd2, 20'hFFFFF}, '{8'd8, 14'h1234, 3'd3, 3'd1, 20'h091A0},
        '{8'd3, 14'h0005, 3'd0, 3'd0, 20'h0000F}};
    logic [7:0] rst_a [6] = '{`REG_MODE, `REG_FSEL, `REG_AVG, `REG_PCNT_A, `REG_CLK, `REG_IO};
    logic [15:0] rst_v [6] = '{`MODE_RST, `FSEL_RST, `AVG_RST, `PCNT_RST, `CLK_RST, `IO_RST};

    sensor_link_if lnk ();
    sample_host_ctrl sample_host_ctrl_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .lnk(lnk), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
    sample_sequencer_dev sample_sequencer_dev_inst (.clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in), .lnk(lnk), .adc_valid_in(adc_valid), .adc_data_in(adc_data),
        .pulse_req_out(pulse_req), .fifo_valid_out(fifo_valid), .fifo_data_out(fifo_data),
        .fifo_slot_out(fifo_slot), .mode_out(mode));
    seq_link_properties seq_link_properties_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_wr(lnk.reg_wr),
        .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata), .reg_ack(lnk.reg_ack),
        .adc_valid_in(adc_valid), .pulse_req_out(pulse_req), .fifo_valid_out(fifo_valid),
        .mode_out(mode));

    initial begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    // converter answers each request with a one-cycle strobe; counts pushes per slot
    always @(posedge clk_sys_in) begin
        adc_valid <= (pulse_req === 1'b1) && !adc_valid;
        if (fifo_valid === 1'b1) begin
            slot_cnt[fifo_slot] <= slot_cnt[fifo_slot] + 1;
            last_data[fifo_slot] <= fifo_data;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : step

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge clk_sys_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one device register access relayed by the host, waits until not busy
    task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d,
            output logic [15:0] r);
        logic [31:0] q;
        logic e;
        apb(1'b1, `APB_CMD, {7'h00, w, d, a}, q, e);
        do apb(1'b0, `APB_STAT, 32'h0, q, e); while (q[0] !== 1'b0);
        r = q[31:16];
    endtask : dev

    task automatic wait_push(input int sl, input int cnt);
        int k;
        for (k = 0; k < 40000 && slot_cnt[sl] < cnt; k++) @(posedge clk_sys_in);
        chk(32'(slot_cnt[sl] >= cnt), 32'h1);
    endtask : wait_push

    function automatic int total();
        return slot_cnt[0] + slot_cnt[1];
    endfunction : total

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    initial begin
        step(100000);
        bad_count++;
        complete_run();
    end

    initial begin
        logic [15:0] r, hi;
        logic [31:0] x, ex;
        logic e;
        int q, s, k;
        step(16);
        resetn_in <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            ex = 32'(rows[i].ex);
            adc_data <= rows[i].adc;
            dev(1'b1, `REG_MODE, 16'h0001, r);
            dev(1'b1, `REG_PCNT_A, {rows[i].n, 8'h00}, r);
            dev(1'b1, `REG_PCNT_B, {rows[i].n, 8'h00}, r);
            dev(1'b1, `REG_AVG, {5'h00, rows[i].lb, 1'b0, rows[i].la, 4'h0}, r);
            dev(1'b1, `REG_FSEL, 16'h0001, r);
            q = slot_cnt[0];
            s = slot_cnt[1];
            dev(1'b1, `REG_MODE, 16'h0002, r);
            chk(32'(mode), 32'h2);
            wait_push(0, q + 2);
            chk(last_data[0], ex);
            if (rows[i].la == rows[i].lb) begin
                wait_push(1, s + 2);
                chk(last_data[1], ex);
            end else begin
                chk(slot_cnt[1], s);
            end
            dev(1'b1, `REG_MODE, 16'h0001, r);
            dev(1'b0, `REG_OUT_A_LO, 16'h0000, r);
            dev(1'b0, `REG_OUT_A_HI, 16'h0000, hi);
            chk({hi, r}, ex << rows[i].la);
            q = total();
            step(2 * TK);
            chk(total(), q);
            $display("row %0d done at %0t", i, $time);
        end
        for (int p = 0; p < 2; p++) begin
            x = p ? 32'hC : 32'h3;
            apb(1'b1, `APB_PINS, x & 32'hA, x, e);
            x = p ? 32'hC : 32'h3;
            dev(1'b1, `REG_MODE, 16'h0001, r);
            dev(1'b1, `REG_IO, p ? 16'h0028 : 16'h0006, r);
            dev(1'b1, `REG_SYNC, 16'h4000, r);
            dev(1'b1, `REG_MODE, 16'h0002, r);
            q = total();
            step(3 * TK);
            chk(total(), q);
            apb(1'b1, `APB_PINS, x, x, e);
            for (k = 0; k < 3 * TK && pulse_req !== 1'b1; k++) @(posedge clk_sys_in);
            chk(32'(k >= TK - 8 && k <= 2 * TK + 16), 32'h1);
            wait_push(0, slot_cnt[0] + 1);
            apb(1'b1, `APB_PINS, p ? 32'h8 : 32'h2, x, e);
            dev(1'b1, `REG_MODE, 16'h0001, r);
            $display("sync pin %0d done at %0t", p, $time);
        end
        apb(1'b1, `APB_PINS, 32'h8, x, e);
        dev(1'b1, `REG_IO, 16'h0020, r);
        dev(1'b1, `REG_CLK, 16'h0100, r);
        dev(1'b1, `REG_MODE, 16'h0002, r);
        q = total();
        step(3 * TK);
        chk(total(), q);
        repeat (24) begin
            apb(1'b1, `APB_PINS, 32'hC, x, e);
            step(3);
            apb(1'b1, `APB_PINS, 32'h8, x, e);
            step(3);
        end
        chk(32'(total() > q), 32'h1);
        $display("external clock done at %0t", $time);
        @(posedge clk_sys_in);
        resetn_in <= 1'b0;
        step(16);
        resetn_in <= 1'b1;
        chk(32'(mode), 32'h0);
        for (int i = 0; i < 6; i++) begin
            dev(1'b0, rst_a[i], 16'h0000, r);
            chk(32'(r), 32'(rst_v[i]));
        end
        q = total();
        step(3 * TK);
        chk(total(), q);
        apb(1'b0, 12'h00C, 32'h0, x, e);
        chk(32'(e), 32'h1);
        $display("reset and unmapped done at %0t", $time);
        complete_run();
    end
endmodule : tb_top
